// ---- rtl/pfs_cfg.svh ----
`ifndef PFS_CFG_SVH
`define PFS_CFG_SVH
// register byte offsets on the bus
`define PFS_OFS_PORT_D 12'h000
`define PFS_OFS_PORT_E 12'h004
// power-on values
`define PFS_RST_PORT_D 16'hAAAA
`define PFS_RST_PORT_E_EMU_HI 16'hAAAA
`define PFS_RST_PORT_E_EMU_LO 16'h2AA8
// field codes
`define PFS_CODE_ALT 2'h0
`define PFS_CODE_OUT 2'h1
`define PFS_CODE_IN_PU 2'h2
`define PFS_CODE_IN_NOPU 2'h3
`define PFS_PINS 8
`define PFS_ADDR_W 12
`endif

// ---- rtl/pfs_pkg.sv ----
`default_nettype none
package pfs_pkg;
  // decoded function of one pin
  typedef struct packed {
    logic alt_sel;
    logic out_en;
    logic in_en;
    logic pullup_en;
    logic reserved;
  } pfs_pin_t;
  typedef enum logic [1:0] {
    PFS_IDLE = 2'b00,
    PFS_ACCESS = 2'b01
  } pfs_state_t;
endpackage
`default_nettype wire

// ---- rtl/pfs_top.sv ----
// Notes on behaviour
// [R1] port D register, 16 bits, powers up AAAA
// [R2] only power-on reset reinitialises both registers
// [R3] pin n owns bits 2n+1 and 2n
// [R4] port D pins 0-3: alt, out, pull-up input, input
// [R5] port D pins 5,7: alt, out, input no pull-up
// [R6] port D pins 4,6: alt, reserved, inputs, no output
// [R7] software never writes reserved codes
// [R8] port E power-up value follows emulator pin
// [R9] port E pins 0,7: full four-way decode
// [R10] no alt on E0/E7 with emulator pin high; the decode still gives alt on E0/E7 whatever the emulator pin
// [R11] port E pins 1,3-6: reserved, out, input
// [R12] port E pin 2: alt, out, input no pull-up
// [R13] new field takes effect cycle after write
//
// Local design decisions: the address map and register access over APB.
`include "pfs_cfg.svh"
`default_nettype none
module pfs_top (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic POR,
  input wire logic EMU_MODE_PIN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [`PFS_ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic [7:0] PD_ALT_SEL,
  output logic [7:0] PD_OUT_EN,
  output logic [7:0] PD_PULLUP_EN,
  output logic [7:0] PD_RESERVED,
  output logic [7:0] PE_ALT_SEL,
  output logic [7:0] PE_OUT_EN,
  output logic [7:0] PE_PULLUP_EN,
  output logic [7:0] PE_RESERVED
);
  // pin classes, one bit per pin
  localparam logic [7:0] D_NO_OUT = 8'h50;
  localparam logic [7:0] D_NO_PU = 8'hA0;
  localparam logic [7:0] E_NO_ALT = 8'h7A;
  localparam logic [7:0] E_NO_PU = 8'h7E;

  // decode of one field; pull-up only where the class allows it
  function automatic pfs_pkg::pfs_pin_t pfs_decode(input logic [1:0] code,
                                                  input logic no_out,
                                                  input logic no_alt,
                                                  input logic no_pu);
    pfs_pkg::pfs_pin_t p;
    p = '0;
    case (code)
      `PFS_CODE_ALT: begin
        p.alt_sel = !no_alt;
        p.reserved = no_alt;
      end
      `PFS_CODE_OUT: begin
        p.out_en = !no_out;
        p.reserved = no_out;
      end
      `PFS_CODE_IN_PU: begin
        p.in_en = 1'b1;
        p.pullup_en = !no_pu;
      end
      default: p.in_en = 1'b1;
    endcase
    return p;
  endfunction

  // ==========================================================
  // emulator pin synchroniser and power-on capture
  logic emu_s1_reg, emu_s2_reg;
  always_ff @(posedge SYS_CLK) begin
    emu_s1_reg <= EMU_MODE_PIN;
    emu_s2_reg <= emu_s1_reg;
  end

  // ==========================================================
  // APB slave, one wait-free access phase
  logic [15:0] port_d_function_select_reg;
  logic [15:0] port_e_function_select_reg;
  wire sel_d = PADDR == `PFS_OFS_PORT_D;
  wire sel_e = PADDR == `PFS_OFS_PORT_E;
  wire acc = PSEL && PENABLE;
  wire wr_d = acc && PWRITE && sel_d;
  wire wr_e = acc && PWRITE && sel_e;
  wire [15:0] wmask = {{8{PSTRB[1]}}, {8{PSTRB[0]}}};
  wire [15:0] d_next = (port_d_function_select_reg & ~wmask) | (PWDATA[15:0] & wmask);
  wire [15:0] e_next = (port_e_function_select_reg & ~wmask) | (PWDATA[15:0] & wmask);
  wire [15:0] rd_sel = sel_d ? port_d_function_select_reg :
                       sel_e ? port_e_function_select_reg : 16'h0000;
  wire [15:0] e_por = emu_s2_reg ? `PFS_RST_PORT_E_EMU_HI : `PFS_RST_PORT_E_EMU_LO;

  // RST (manual/standby) leaves the selects alone; POR reloads them
  always_ff @(posedge SYS_CLK) begin
    if (POR) begin // [R2]
      port_d_function_select_reg <= `PFS_RST_PORT_D; // [R1]
      port_e_function_select_reg <= e_por; // [R8]
    end else begin
      if (wr_d) port_d_function_select_reg <= d_next; // [R1]
      if (wr_e) port_e_function_select_reg <= e_next; // [R8]
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST || POR) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h00000000;
    end else begin
      PREADY <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && !(sel_d || sel_e);
      PRDATA <= (PSEL && !PENABLE && !PWRITE) ? {16'h0000, rd_sel} : 32'h00000000;
    end
  end

  // ==========================================================
  // per-pin decode, registered onto the outputs
  pfs_pkg::pfs_pin_t d_pin [`PFS_PINS];
  pfs_pkg::pfs_pin_t e_pin [`PFS_PINS];
  genvar n;
  generate
    for (n = 0; n < `PFS_PINS; n++) begin : g_pin
      // [R3] [R4] [R5] [R6]
      assign d_pin[n] = pfs_decode(port_d_function_select_reg[2*n+1 -: 2],
                                   D_NO_OUT[n], 1'b0, D_NO_PU[n]);
      // [R9] [R11] [R12]
      assign e_pin[n] = pfs_decode(port_e_function_select_reg[2*n+1 -: 2],
                                   1'b0, E_NO_ALT[n], E_NO_PU[n]);
      always_ff @(posedge SYS_CLK) begin // [R13]
        PD_ALT_SEL[n] <= d_pin[n].alt_sel;
        PD_OUT_EN[n] <= d_pin[n].out_en;
        PD_PULLUP_EN[n] <= d_pin[n].pullup_en;
        PD_RESERVED[n] <= d_pin[n].reserved;
        PE_ALT_SEL[n] <= e_pin[n].alt_sel;
        PE_OUT_EN[n] <= e_pin[n].out_en;
        PE_PULLUP_EN[n] <= e_pin[n].pullup_en;
        PE_RESERVED[n] <= e_pin[n].reserved;
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ---- test/pfs_top_sva.sv ----
`default_nettype none
module pfs_chk(
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic POR,
  input wire logic EMU_MODE_PIN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic PREADY,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  input wire logic [7:0] PD_PULLUP_EN,
  input wire logic [7:0] PE_ALT_SEL,
  input wire logic [7:0] PE_PULLUP_EN
);
  // ==========
  // landed writes, both bytes strobed
  wire wr = PSEL && PENABLE && PREADY && PWRITE && (&PSTRB[1:0]);
  wire wd = wr && PADDR == 12'h000;
  wire we = wr && PADDR == 12'h004;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (POR);
  pd_pu_a: assert property (wd |-> ##2 PD_PULLUP_EN[0] == ($past(PWDATA[1:0], 2) == 2'h2))
    else $error("pd0 pull-up");
  pd_pu4_a: assert property (wd |-> ##2 PD_PULLUP_EN[4] == ($past(PWDATA[9:8], 2) == 2'h2))
    else $error("pd4 pull-up");
  pd_nopu_a: assert property (!PD_PULLUP_EN[7] && !PD_PULLUP_EN[5])
    else $error("pd5 pull-up");
  pe_alt_a: assert property (we |-> ##2 PE_ALT_SEL[7] == ($past(PWDATA[15:14], 2) == 2'h0))
    else $error("pe7 alt");
  pe_noalt_a: assert property (PE_ALT_SEL[6:3] == 4'h0 && !PE_ALT_SEL[1])
    else $error("pe alt");
  pd_por_a: assert property ($fell(POR) |-> PD_PULLUP_EN == 8'h5F)
    else $error("pd power-on");
  pe_por_a: assert property ($fell(POR) |-> PE_PULLUP_EN == (EMU_MODE_PIN ? 8'h81 : 8'h00))
    else $error("pe power-on");
  keep_sel_a: assert property (RST |=> $stable(PD_PULLUP_EN))
    else $error("select lost");
  cover property (wd);
  cover property (we);
  cover property ($fell(POR) && !EMU_MODE_PIN);
endmodule
bind pfs_top pfs_chk chk(.*);
`default_nettype wire

// ---- test/test_port_d_e_pin_function_select.sv ----
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin fails++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module test_port_d_e_pin_function_select;
  timeunit 1ns;
  timeprecision 1ps;
  logic SYS_CLK = 0, RST = 1, POR = 1, EMU_MODE_PIN = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [11:0] PADDR = 12'h0;
  logic [31:0] PWDATA = 32'h0, PRDATA, r, q;
  logic [3:0] PSTRB = 4'hF;
  logic PREADY, PSLVERR, p, er;
  logic [7:0] PD_ALT_SEL, PD_OUT_EN, PD_PULLUP_EN, PD_RESERVED;
  logic [7:0] PE_ALT_SEL, PE_OUT_EN, PE_PULLUP_EN, PE_RESERVED;
  logic [15:0] w, v[2];
  int fails = 0, num_checks = 0, cyc = 0;
  always #4 SYS_CLK = ~SYS_CLK;
  pfs_top uut(.*);
  // ==========
  // expected {reserved, pull-up, out, alt} of one port
  function automatic logic [31:0] ex(input logic e, input logic [15:0] x);
    logic [1:0] c;
    logic f, rs;
    ex = 32'h0;
    for (int i = 0; i < 8; i++) begin
      c = x[2*i+:2];
      f = e ? i % 7 == 0 : i != 5 && i != 7;
      rs = e ? i % 7 != 0 && i != 2 && c == 2'h0 : (i == 4 || i == 6) && c == 2'h1;
      ex[i] = c == 2'h0 && !rs;
      ex[8 + i] = c == 2'h1 && !rs;
      ex[16 + i] = c == 2'h2 && f;
      ex[24 + i] = rs;
    end
  endfunction
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [15:0] d);
    @(posedge SYS_CLK);
    PSEL <= 1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= {16'h0, d};
    @(posedge SYS_CLK);
    PENABLE <= 1;
    do @(posedge SYS_CLK); while (PREADY !== 1'b1);
    r = PRDATA;
    er = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc > 5000) begin
      fails++;
      test_done();
    end
  end
  initial begin
    void'($urandom(32'hFC561E1F));
    for (int m = 1; m >= 0; m--) begin
      EMU_MODE_PIN <= m[0];
      POR <= 1;
      RST <= 1;
      repeat (16) @(posedge SYS_CLK);
      POR <= 0;
      RST <= 0;
      v[0] = 16'hAAAA;
      v[1] = m ? 16'hAAAA : 16'h2AA8;
      for (int t = 0; t < 22; t++) begin
        p = $urandom_range(1);
        w = $urandom;
        q = ex(p, w);
        for (int i = 0; i < 8; i++)
          if (q[24 + i] || (p && m && i % 7 == 0 && w[2*i+:2] == 2'h0)) w[2*i+:2] = 2'h3;
        if (t == 21) begin
          RST <= 1;
          repeat (16) @(posedge SYS_CLK);
          RST <= 0;
        end else if (t > 0) begin
          xfer(1, {9'h0, p, 2'h0}, w);
          v[p] = w;
        end
        // pin outputs trail the landed write by one more edge
        repeat (2) @(negedge SYS_CLK);
        `CHK("pins", {ex(0, v[0]), ex(1, v[1])}, {PD_RESERVED, PD_PULLUP_EN, PD_OUT_EN, PD_ALT_SEL, PE_RESERVED, PE_PULLUP_EN, PE_OUT_EN, PE_ALT_SEL})
        xfer(0, 12'h000, 16'h0);
        `CHK("port d", {16'h0, v[0]}, r)
        `CHK("port d err", 1'b0, er)
        xfer(0, 12'h004, 16'h0);
        `CHK("port e", {16'h0, v[1]}, r)
      end
      $display("emulator pin %0d pass done", m);
    end
    test_done();
  end
endmodule
`default_nettype wire
